// File: hw/axw_pkg.sv
package axw_pkg;

  localparam int NUM_AXES = 3;
  localparam int POS_W = 32;
  localparam int ADDR_W = 12;

  // Register map, per axis block
  localparam logic [11:0] AXIS_STRIDE = 12'h020;
  localparam logic [2:0] IDX_RANGE = 3'h0;     // 0x00 repeat_range
  localparam logic [2:0] IDX_OPTIONS = 3'h1;   // 0x04 position_wrap_options
  localparam logic [2:0] IDX_DEMAND = 3'h2;    // 0x08 demand_position, RO
  localparam logic [2:0] IDX_MEASURED = 3'h3;  // 0x0C measured_position, RO
  localparam logic [2:0] IDX_TARGET = 3'h4;    // 0x10 end position to remap
  localparam logic [2:0] IDX_STATUS = 3'h5;    // 0x14 status, RO
  localparam int AXIS_LSB = 5;
  localparam int IDX_LSB = 2;

  localparam int OPT_ZERO_BASED_BIT = 0;
  localparam int OPT_REPEAT_END_BIT = 1;
  localparam logic [1:0] OPTIONS_RESET = 2'h0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REPEAT_BIT = 1;

  localparam logic [31:0] RANGE_RESET_AXIS0 = 32'h8000_0000;
  localparam logic [31:0] RANGE_RESET_OTHER = 32'h004C_4B40;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Servo cycle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SERVO_PERIOD_NS = 1000000;
  localparam int SERVO_CYCLES = SERVO_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    AXW_IDLE = 2'b01,
    AXW_FOLD = 2'b10
  } axw_fold_e;

  // One span step toward the range; bit 32 flags that a step was taken
  function automatic logic [32:0] axw_fold_once(
    input logic [31:0] value,
    input logic [31:0] range,
    input logic zero_based
  );
    logic signed [33:0] sv;
    logic signed [33:0] sr;
    logic signed [33:0] lo;
    logic signed [33:0] span;
    logic [33:0] res;
    sv = {{2{value[31]}}, value};
    sr = {2'b00, range};
    lo = zero_based ? 34'sh0 : -sr;
    span = zero_based ? sr : sr + sr;
    res = sv;
    if (sv >= sr) begin
      res = sv - span;
    end else if (sv < lo) begin
      res = sv + span;
    end
    return {(res != sv), res[31:0]};
  endfunction

  function automatic logic [31:0] axw_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~mask) | (data & mask);
  endfunction

endpackage

// File: hw/axw_axis.sv
`timescale 1ns/1ps
module axw_axis #(
  parameter logic [31:0] RANGE_RESET = axw_pkg::RANGE_RESET_OTHER
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic servo_tick,
  input wire logic [31:0] demand_step,
  input wire logic [31:0] measured_step,
  input wire logic wr_range,
  input wire logic wr_opt,
  input wire logic wr_target,
  input wire logic [31:0] wr_data,
  input wire logic repeat_stopped,
  output logic [31:0] range_reg,
  output logic [1:0] opt_reg,
  output logic [31:0] demand_position_reg,
  output logic [31:0] measured_position_reg,
  output logic [31:0] target_reg,
  output logic busy_reg,
  output logic wrap_reg,
  output logic target_done_reg
);

  axw_pkg::axw_fold_e state_reg;
  logic [31:0] d_sum;
  logic [31:0] m_sum;
  logic [32:0] m_fold;
  logic [32:0] t_fold;
  logic [31:0] delta;
  logic zb;

  assign zb = opt_reg[axw_pkg::OPT_ZERO_BASED_BIT];
  assign d_sum = demand_position_reg + demand_step;
  assign m_sum = measured_position_reg + measured_step;
  // Only the measured position decides the fold
  assign m_fold = axw_pkg::axw_fold_once(m_sum, range_reg, zb);
  assign t_fold = axw_pkg::axw_fold_once(target_reg, range_reg, zb);
  assign delta = m_fold[31:0] - m_sum;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      range_reg <= RANGE_RESET;
    end else if (wr_range && wr_data != 32'h0000_0000) begin
      // Zero would make the span empty, so such a write is dropped
      range_reg <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_reg <= axw_pkg::OPTIONS_RESET;
    end else if (wr_opt) begin
      // A write in the same cycle as the stop keeps the new request
      opt_reg <= wr_data[1:0];
    end else if (repeat_stopped) begin
      opt_reg[axw_pkg::OPT_REPEAT_END_BIT] <= 1'b0;
    end
  end

  // Same offset goes into both positions, following error unchanged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      demand_position_reg <= 32'h0000_0000;
      measured_position_reg <= 32'h0000_0000;
      wrap_reg <= 1'b0;
    end else begin
      wrap_reg <= servo_tick && m_fold[32];
      if (servo_tick) begin
        measured_position_reg <= m_fold[31:0];
        demand_position_reg <= d_sum + delta;
      end
    end
  end

  // One span per cycle until the end position lies inside the range
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= axw_pkg::AXW_IDLE;
      target_reg <= 32'h0000_0000;
      target_done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      target_done_reg <= 1'b0;
      if (wr_target) begin
        target_reg <= wr_data;
        state_reg <= axw_pkg::AXW_FOLD;
        busy_reg <= 1'b1;
      end else begin
        case (state_reg)
          axw_pkg::AXW_IDLE: begin
            busy_reg <= 1'b0;
          end
          axw_pkg::AXW_FOLD: begin
            if (t_fold[32]) begin
              target_reg <= t_fold[31:0];
            end else begin
              state_reg <= axw_pkg::AXW_IDLE;
              target_done_reg <= 1'b1;
              busy_reg <= 1'b0;
            end
          end
          default: begin
            state_reg <= axw_pkg::AXW_IDLE;
            busy_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // axw_axis

// File: hw/axw_position_wrap.sv
`timescale 1ns/1ps
// How it works
// - At range limit, shift both positions; move and servo undisturbed.
// - Only the measured position triggers the shift; demand may lie outside.
// - A supplied end position outside the range is remapped inside it.
// - Reset range is 2147483648 on axis 0, 5000000 on axes 1 and 2.
// - Option bit 0 clear: positions kept between minus and plus range.
// - Option bit 0 set: positions kept between zero and range.
// - Bit 1 requests repeat end; hardware clears it once repeat is off.
// - Option word resets to zero: symmetric, no repeat-end request.
module axw_position_wrap #(
  parameter int SERVO_CYCLES = axw_pkg::SERVO_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [95:0] DEMAND_STEP,
  input wire logic [95:0] MEASURED_STEP,
  input wire logic [2:0] REPEAT_STOPPED,
  output logic SERVO_TICK,
  output logic [95:0] DEMAND_POSITION,
  output logic [95:0] MEASURED_POSITION,
  output logic [95:0] TARGET_POSITION,
  output logic [2:0] TARGET_DONE,
  output logic [2:0] WRAP_PULSE,
  output logic [2:0] REPEAT_END_REQ
);

  localparam int N = axw_pkg::NUM_AXES;

  logic [31:0] div_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic wr_hit;
  logic [1:0] wr_axis;
  logic [2:0] wr_idx;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [1:0] rd_axis;
  logic [2:0] rd_idx;

  logic [N-1:0] wr_range;
  logic [N-1:0] wr_opt;
  logic [N-1:0] wr_target;
  logic [31:0] wr_data [N];
  logic [31:0] range_q [N];
  logic [1:0] opt_q [N];
  logic [31:0] demand_position_q [N];
  logic [31:0] measured_position_q [N];
  logic [31:0] target_q [N];
  logic [N-1:0] busy_q;
  logic [N-1:0] wrap_q;
  logic [N-1:0] done_q;

  // Servo cycle divider
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= 32'h0000_0000;
      SERVO_TICK <= 1'b0;
    end else if (div_reg == 32'(SERVO_CYCLES - 1)) begin
      div_reg <= 32'h0000_0000;
      SERVO_TICK <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      SERVO_TICK <= 1'b0;
    end
  end

  // Write channel: address and data taken in either order
  assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_axis = awaddr_reg[axw_pkg::AXIS_LSB +: 2];
  assign wr_idx = awaddr_reg[axw_pkg::IDX_LSB +: 3];
  assign wr_hit = awaddr_reg[11:7] == 5'h00 && awaddr_reg[1:0] == 2'h0 &&
    wr_axis < 2'(N) && (wr_idx == axw_pkg::IDX_RANGE ||
    wr_idx == axw_pkg::IDX_OPTIONS || wr_idx == axw_pkg::IDX_TARGET);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      awaddr_reg <= 12'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      S_AXI_AWREADY <= 1'b0;
      awaddr_reg <= S_AXI_AWADDR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_WREADY <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      S_AXI_WREADY <= 1'b0;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= axw_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? axw_pkg::RESP_OKAY : axw_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Register read mux
  assign rd_axis = S_AXI_ARADDR[axw_pkg::AXIS_LSB +: 2];
  assign rd_idx = S_AXI_ARADDR[axw_pkg::IDX_LSB +: 3];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = S_AXI_ARADDR[11:7] == 5'h00 && S_AXI_ARADDR[1:0] == 2'h0 &&
      rd_axis < 2'(N);
    if (rd_hit) begin
      case (rd_idx)
        axw_pkg::IDX_RANGE: rd_data = range_q[rd_axis];
        axw_pkg::IDX_OPTIONS: rd_data = {30'h0000_0000, opt_q[rd_axis]};
        axw_pkg::IDX_DEMAND: rd_data = demand_position_q[rd_axis];
        axw_pkg::IDX_MEASURED: rd_data = measured_position_q[rd_axis];
        axw_pkg::IDX_TARGET: rd_data = target_q[rd_axis];
        axw_pkg::IDX_STATUS: begin
          rd_data[axw_pkg::STAT_BUSY_BIT] = busy_q[rd_axis];
          rd_data[axw_pkg::STAT_REPEAT_BIT] =
            opt_q[rd_axis][axw_pkg::OPT_REPEAT_END_BIT];
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= axw_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? axw_pkg::RESP_OKAY : axw_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Per-axis wrap logic
  for (genvar a = 0; a < N; a++) begin : g_axis
    always_comb begin
      wr_range[a] = do_write && wr_hit && wr_axis == 2'(a) &&
        wr_idx == axw_pkg::IDX_RANGE;
      wr_opt[a] = do_write && wr_hit && wr_axis == 2'(a) &&
        wr_idx == axw_pkg::IDX_OPTIONS && wstrb_reg[0];
      wr_target[a] = do_write && wr_hit && wr_axis == 2'(a) &&
        wr_idx == axw_pkg::IDX_TARGET;
      wr_data[a] = axw_pkg::axw_merge(
        wr_idx == axw_pkg::IDX_TARGET ? target_q[a] : range_q[a],
        wdata_reg, wstrb_reg);
      if (wr_idx == axw_pkg::IDX_OPTIONS) begin
        wr_data[a] = wdata_reg;
      end
    end

    axw_axis #(
      .RANGE_RESET(a == 0 ? axw_pkg::RANGE_RESET_AXIS0
                          : axw_pkg::RANGE_RESET_OTHER)
    ) u_axis (
      .clk(REF_CLK),
      .rst(RESET),
      .servo_tick(SERVO_TICK),
      .demand_step(DEMAND_STEP[a*32 +: 32]),
      .measured_step(MEASURED_STEP[a*32 +: 32]),
      .wr_range(wr_range[a]),
      .wr_opt(wr_opt[a]),
      .wr_target(wr_target[a]),
      .wr_data(wr_data[a]),
      .repeat_stopped(REPEAT_STOPPED[a]),
      .range_reg(range_q[a]),
      .opt_reg(opt_q[a]),
      .demand_position_reg(demand_position_q[a]),
      .measured_position_reg(measured_position_q[a]),
      .target_reg(target_q[a]),
      .busy_reg(busy_q[a]),
      .wrap_reg(wrap_q[a]),
      .target_done_reg(done_q[a])
    );

    // Axis outputs are already flip-flops inside the axis block
    assign DEMAND_POSITION[a*32 +: 32] = demand_position_q[a];
    assign MEASURED_POSITION[a*32 +: 32] = measured_position_q[a];
    assign TARGET_POSITION[a*32 +: 32] = target_q[a];
    assign TARGET_DONE[a] = done_q[a];
    assign WRAP_PULSE[a] = wrap_q[a];
    assign REPEAT_END_REQ[a] = opt_q[a][axw_pkg::OPT_REPEAT_END_BIT];
  end

endmodule // axw_position_wrap

// File: bench/axw_wrap_asserts.sv
`timescale 1ns/1ps
module axw_wrap_asserts (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [95:0] DEMAND_STEP,
  input wire logic [95:0] MEASURED_STEP,
  input wire logic [2:0] REPEAT_STOPPED,
  input wire logic SERVO_TICK,
  input wire logic [95:0] DEMAND_POSITION,
  input wire logic [95:0] MEASURED_POSITION,
  input wire logic [95:0] TARGET_POSITION,
  input wire logic [2:0] TARGET_DONE,
  input wire logic [2:0] WRAP_PULSE,
  input wire logic [2:0] REPEAT_END_REQ
);
  wire [31:0] d0 = DEMAND_POSITION[31:0];
  wire [31:0] m0 = MEASURED_POSITION[31:0];
  wire [31:0] ds0 = DEMAND_STEP[31:0];
  wire [31:0] ms0 = MEASURED_STEP[31:0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_same_shift;
    SERVO_TICK |=> d0 - m0 == $past(d0 - m0 + ds0 - ms0);
  endproperty
  a_same_shift: assert property (p_same_shift)
    else $error("following error changed by a wrap");
  property p_wrap_flag;
    SERVO_TICK |=> WRAP_PULSE[0] == (m0 != $past(m0 + ms0));
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap pulse does not match position shift");
  property p_demand_plain;
    SERVO_TICK ##1 !WRAP_PULSE[0] |-> d0 == $past(d0 + ds0);
  endproperty
  a_demand_plain: assert property (p_demand_plain)
    else $error("demand shifted without a measured wrap");
  property p_hold_between;
    !SERVO_TICK |=> $stable(DEMAND_POSITION) && $stable(MEASURED_POSITION);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("positions moved without a servo tick");
  property p_wrap_after_tick;
    WRAP_PULSE != 3'h0 |-> $past(SERVO_TICK);
  endproperty
  a_wrap_after_tick: assert property (p_wrap_after_tick)
    else $error("wrap pulse without a servo tick");
  property p_stop_clears;
    S_AXI_AWREADY |=> !(REPEAT_END_REQ & $past(REPEAT_STOPPED));
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("repeat end request not cleared");
  property p_req_by_write;
    (REPEAT_END_REQ & ~$past(REPEAT_END_REQ)) != 3'h0 |-> S_AXI_BVALID;
  endproperty
  a_req_by_write: assert property (p_req_by_write)
    else $error("repeat end request rose without a write");
  property p_target_final;
    TARGET_DONE != 3'h0 |=> $stable(TARGET_POSITION);
  endproperty
  a_target_final: assert property (p_target_final)
    else $error("end position moved after done");
  property p_read_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read answer dropped early");
  c_wrap: cover property (WRAP_PULSE[0]);
  c_done: cover property (TARGET_DONE[1]);
  c_req: cover property (REPEAT_END_REQ[2]);
endmodule // axw_wrap_asserts

bind axw_position_wrap axw_wrap_asserts u_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .DEMAND_STEP(DEMAND_STEP), .MEASURED_STEP(MEASURED_STEP),
  .REPEAT_STOPPED(REPEAT_STOPPED), .SERVO_TICK(SERVO_TICK),
  .DEMAND_POSITION(DEMAND_POSITION), .MEASURED_POSITION(MEASURED_POSITION),
  .TARGET_POSITION(TARGET_POSITION), .TARGET_DONE(TARGET_DONE),
  .WRAP_PULSE(WRAP_PULSE), .REPEAT_END_REQ(REPEAT_END_REQ));

// File: bench/axw_position_wrap_bench.sv
`timescale 1ns/1ps
module axw_position_wrap_bench;
  localparam logic [31:0] TV [3] =
    '{32'h0000_01C2, 32'hFFFF_FEA2, 32'h0000_00FA};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [95:0] dstep = 96'h0, mstep = 96'h0;
  logic [2:0] rstop = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, q;
  logic [95:0] demand_position, measured_position, tpos;
  logic [2:0] tdone, wrap, req;
  logic [31:0] md [3], mm [3], rg [3];
  logic zb [3];
  int n_errors = 0, checked = 0, n, ax;
  always #10 clk = ~clk;
  axw_position_wrap #(.SERVO_CYCLES(8)) DUT (
    .REF_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .DEMAND_STEP(dstep), .MEASURED_STEP(mstep),
    .REPEAT_STOPPED(rstop), .SERVO_TICK(tick), .DEMAND_POSITION(demand_position),
    .MEASURED_POSITION(measured_position), .TARGET_POSITION(tpos), .TARGET_DONE(tdone),
    .WRAP_PULSE(wrap), .REPEAT_END_REQ(req));
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ad(input int a, input logic [2:0] i);
    return 12'(a * 32) | {7'h00, i, 2'h0};
  endfunction
  // Handshake decisions use settled values just before the taking edge
  task automatic bus(input logic wr, input logic [11:0] adr,
    input logic [31:0] d, output logic [31:0] rd, output logic [1:0] rp);
    logic a, w, b, v;
    @(posedge clk);
    if (wr) begin
      awaddr <= adr;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= adr;
      arvalid <= 1'b1;
    end
    do begin
      #1;
      a = wr ? awvalid & awready : arvalid & arready;
      w = wvalid & wready;
      b = wr ? bvalid & bready : rvalid & rready;
      v = !wr && rvalid;
      rd = rdata;
      rp = wr ? bresp : rresp;
      @(posedge clk);
      if (a && wr) awvalid <= 1'b0;
      if (a && !wr) arvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      // Read ready held back a cycle so the answer must stand
      if (v && !b) rready <= 1'b1;
    end while (!b);
    if (wr) bready <= 1'b0;
    else rready <= 1'b0;
  endtask
  task automatic tick_chk();
    logic signed [33:0] m, r, sh;
    #1;
    while (tick !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    for (int a = 0; a < 3; a++) begin
      m = $signed(mm[a] + mstep[a*32+:32]);
      r = {2'b00, rg[a]};
      sh = 34'sh0;
      if (m >= r) sh = zb[a] ? -r : -2 * r;
      else if (m < (zb[a] ? 34'sh0 : -r)) sh = zb[a] ? r : 2 * r;
      mm[a] = 32'(m + sh);
      md[a] = md[a] + dstep[a*32+:32] + sh[31:0];
      chk(measured_position[a*32+:32], mm[a]);
      chk(demand_position[a*32+:32], md[a]);
      chk({31'h0, wrap[a]}, {31'h0, sh != 34'sh0});
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      bus(0, ad(a, axw_pkg::IDX_RANGE), 32'h0, q, rs);
      chk(q, a == 0 ? 32'h8000_0000 : 32'h004C_4B40);
      bus(0, ad(a, axw_pkg::IDX_OPTIONS), 32'h0, q, rs);
      chk(q, 32'h0);
      md[a] = 32'h0;
      mm[a] = 32'h0;
    end
    chk({29'h0, req}, 32'h0);
    bus(0, 12'h01C, 32'h0, q, rs);
    chk(q, 32'h0);
    chk(32'(rs), 32'(axw_pkg::RESP_SLVERR));
    bus(1, ad(0, axw_pkg::IDX_DEMAND), 32'h5, q, rs);
    chk(32'(rs), 32'(axw_pkg::RESP_SLVERR));
    bus(1, ad(0, axw_pkg::IDX_RANGE), 32'h0, q, rs);
    chk(32'(rs), 32'(axw_pkg::RESP_OKAY));
    bus(0, ad(0, axw_pkg::IDX_RANGE), 32'h0, q, rs);
    chk(q, 32'h8000_0000);
    for (int a = 0; a < 2; a++) begin
      bus(1, ad(a, axw_pkg::IDX_RANGE), 32'h64, q, rs);
      bus(1, ad(a, axw_pkg::IDX_OPTIONS), 32'(1 - a), q, rs);
      rg[a] = 32'h64;
      zb[a] = a == 0;
    end
    rg[2] = 32'h004C_4B40;
    zb[2] = 1'b0;
    // On axes 0 and 1 demand outruns measured; on axis 0 it leaves the range between wraps
    mstep <= {32'hFFFF_FFF9, 32'h0000_0046, 32'h0000_001E};
    dstep <= {32'hFFFF_FFF9, 32'h0000_0047, 32'h0000_0028};
    repeat (12) tick_chk();
    bus(1, ad(2, axw_pkg::IDX_OPTIONS), 32'h2, q, rs);
    #1;
    chk({29'h0, req}, 32'h4);
    bus(0, ad(2, axw_pkg::IDX_STATUS), 32'h0, q, rs);
    chk(q, 32'h2);
    rstop <= 3'h4;
    @(posedge clk);
    rstop <= 3'h0;
    #1;
    chk({29'h0, req}, 32'h0);
    bus(0, ad(2, axw_pkg::IDX_OPTIONS), 32'h0, q, rs);
    chk(q, 32'h0);
    for (int k = 0; k < 3; k++) begin
      ax = 1 - k / 2;
      bus(1, ad(ax, axw_pkg::IDX_TARGET), TV[k], q, rs);
      #1;
      for (n = 0; n < 20 && tdone[ax] !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      chk(tpos[ax*32+:32], 32'h32);
      chk(32'(n), 32'h2);
    end
    stop_test();
  end
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule // axw_position_wrap_bench
